// file: core/sar_map.svh
// register map, field positions, reset values and codes of the frame reader
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH

`define SAR_CTRL_OFS 8'h00
`define SAR_DIV_OFS 8'h04
`define SAR_INTV_OFS 8'h08
`define SAR_DATA_OFS 8'h0C
`define SAR_STAT_OFS 8'h10

`define SAR_CTRL_EN_BIT 0
`define SAR_CTRL_WLF_LSB 4
`define SAR_CTRL_TRIM_LSB 8
`define SAR_DATA_VALID_BIT 31
`define SAR_STAT_BUSY_BIT 0
`define SAR_STAT_PEND_BIT 1
`define SAR_STAT_OVR_BIT 2
`define SAR_STAT_CNT_LSB 16

`define SAR_WLF_16 4'hF
`define SAR_WLF_14 4'hD
`define SAR_WLF_12 4'hB

`define SAR_EN_RST 1'h0
`define SAR_WLF_RST 4'hF
`define SAR_TRIM_RST 3'h0
`define SAR_DIV_RST 8'h05
`define SAR_INTV_RST 16'h0064
`define SAR_MIN_SLACK 16'h0004

`endif

// file: core/sar_pkg.sv
// types shared by the frame reader files
package sar_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEEK_HI,
    ST_SEEK_LO,
    ST_SEEK_HI2,
    ST_FRAME
  } sar_state_t;

  typedef struct packed {
    logic [2:0] trim;
    logic [3:0] wlf;
    logic en;
  } sar_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } sar_word_t;

endpackage

// file: core/sar_sync3.sv
// three-stage synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module sar_sync3 (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level_out
);
  import sar_pkg::*;

  logic s1_reg, s2_reg, s3_reg, out_reg;
  logic s1_next, s2_next, s3_next, out_next;

  always_comb begin
    s1_next = pin_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
    out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      out_reg <= out_next;
    end
  end

  assign level_out = out_reg;
endmodule

// file: core/sar_reader.sv
// host frame reader for a serial successive-approximation converter, AHB-Lite slave
//
// Contract
// - the frame strobe drives the converter chip select and also gates our own capture.
// - the strobe stays low for the whole word, one strobe per converted word.
// - word-length codes 1111, 1101, 1011 give 16, 14 and 12 bits.
// - a frame starts only after the sample-interval timer expires.
// - after a request the frame waits for the serial clock to go high, low, high.
// - the sample interval is a whole number of serial clock periods.
// - serial clock and frame sync are made here for both directions.
// - a 16-bit read of the 10-bit part drops the final two bits.
// - the 8-bit part may be read with a 12-bit word.
// - strobe active low, strobe and clock are outputs, data MSB first.
// - the strobe falling edge is the sampling instant and starts a conversion.
// - frame starts are equally spaced in time; here only while the interval outlasts the frame.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "sar_map.svh"
module sar_reader (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic serial_clock,
  output logic transmit_frame_strobe_n,
  input wire logic converter_serial_out,
  output sar_pkg::sar_word_t sample_out
);
  import sar_pkg::*;

  // bus-side state
  sar_ctrl_t ctrl_reg, ctrl_next;
  logic [7:0] serial_clock_divider_reg, serial_clock_divider_next;
  logic [15:0] intv_reg, intv_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  sar_word_t word_reg, word_next;
  logic ovr_reg, ovr_next;
  logic [15:0] frames_reg, frames_next;

  // link-side state
  logic sclk_reg, sclk_next;
  logic [7:0] divcnt_reg, divcnt_next;
  logic [15:0] tmr_reg, tmr_next;
  logic pend_reg, pend_next;
  sar_state_t state_reg, state_next;
  logic [4:0] bitcnt_reg, bitcnt_next;
  logic [15:0] shift_reg, shift_next;
  logic strobe_n_reg, strobe_n_next;

  logic converter_serial_out_s;
  logic acc, rd_acc, rd_data, tick, rise_en, fall_en, expire, take, start, done;
  logic [4:0] len;
  logic [15:0] shift_in;

  sar_sync3 u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(converter_serial_out),
    .level_out(converter_serial_out_s)
  );

  assign acc = hsel && hready && htrans[1];
  assign rd_acc = acc && !hwrite;
  assign rd_data = rd_acc && (haddr[7:0] == `SAR_DATA_OFS);

  // serial clock enables from the divider
  assign tick = ctrl_reg.en && (divcnt_reg == serial_clock_divider_reg);
  assign rise_en = tick && !sclk_reg;
  assign fall_en = tick && sclk_reg;
  assign len = {1'b0, ctrl_reg.wlf} + 5'h1;
  assign expire = rise_en && (tmr_reg == intv_reg - 16'h1);
  assign take = (state_reg == ST_IDLE) && pend_reg;
  assign start = (state_reg == ST_SEEK_HI2) && rise_en;
  assign shift_in = {shift_reg[14:0], converter_serial_out_s};
  assign done = (state_reg == ST_FRAME) && fall_en && (bitcnt_reg == len - 5'h1);

  always_comb begin
    divcnt_next = divcnt_reg;
    sclk_next = sclk_reg;
    tmr_next = tmr_reg;
    pend_next = pend_reg;
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    shift_next = shift_reg;
    strobe_n_next = strobe_n_reg;
    if (!ctrl_reg.en) begin
      // disable raises the strobe, an unfinished frame is abandoned
      divcnt_next = 8'h00;
      sclk_next = 1'b0;
      tmr_next = 16'h0000;
      pend_next = 1'b0;
      state_next = ST_IDLE;
      strobe_n_next = 1'b1;
    end else begin
      divcnt_next = tick ? 8'h00 : divcnt_reg + 8'h01;
      sclk_next = tick ? !sclk_reg : sclk_reg;
      if (rise_en) begin
        tmr_next = expire ? 16'h0000 : tmr_reg + 16'h0001;
      end
      pend_next = expire || (pend_reg && !take);
      unique case (state_reg)
        ST_IDLE: begin
          strobe_n_next = 1'b1;
          if (pend_reg) begin
            state_next = ST_SEEK_HI;
          end
        end
        ST_SEEK_HI: begin
          if (rise_en) begin
            state_next = ST_SEEK_LO;
          end
        end
        ST_SEEK_LO: begin
          if (fall_en) begin
            state_next = ST_SEEK_HI2;
          end
        end
        ST_SEEK_HI2: begin
          if (rise_en) begin
            state_next = ST_FRAME;
            strobe_n_next = 1'b0;
            bitcnt_next = 5'h00;
            shift_next = 16'h0000;
          end
        end
        ST_FRAME: begin
          if (fall_en) begin
            // bit present before each falling edge, first one since strobe fall
            shift_next = shift_in;
            bitcnt_next = bitcnt_reg + 5'h1;
            if (done) begin
              state_next = ST_IDLE;
              strobe_n_next = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      divcnt_reg <= 8'h00;
      sclk_reg <= 1'b0;
      tmr_reg <= 16'h0000;
      pend_reg <= 1'b0;
      state_reg <= ST_IDLE;
      bitcnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      strobe_n_reg <= 1'b1;
    end else begin
      divcnt_reg <= divcnt_next;
      sclk_reg <= sclk_next;
      tmr_reg <= tmr_next;
      pend_reg <= pend_next;
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      shift_reg <= shift_next;
      strobe_n_reg <= strobe_n_next;
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    serial_clock_divider_next = serial_clock_divider_reg;
    intv_next = intv_reg;
    wr_pend_next = acc && hwrite;
    wr_addr_next = acc ? haddr[7:0] : wr_addr_reg;
    hrdata_next = hrdata_reg;
    word_next = word_reg;
    ovr_next = ovr_reg;
    frames_next = frames_reg;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `SAR_CTRL_OFS: begin
          ctrl_next.en = hwdata[`SAR_CTRL_EN_BIT];
          ctrl_next.wlf = hwdata[`SAR_CTRL_WLF_LSB +: 4];
          ctrl_next.trim = hwdata[`SAR_CTRL_TRIM_LSB +: 3];
        end
        `SAR_DIV_OFS: serial_clock_divider_next = hwdata[7:0];
        `SAR_INTV_OFS: intv_next = hwdata[15:0];
        default: ;
      endcase
    end
    if (rd_acc) begin
      unique case (haddr[7:0])
        `SAR_CTRL_OFS: hrdata_next = {21'h0, ctrl_reg.trim, ctrl_reg.wlf, 3'h0, ctrl_reg.en};
        `SAR_DIV_OFS: hrdata_next = {24'h0, serial_clock_divider_reg};
        `SAR_INTV_OFS: hrdata_next = {16'h0, intv_reg};
        `SAR_DATA_OFS: hrdata_next = {word_reg.valid, 15'h0, word_reg.word};
        `SAR_STAT_OFS: hrdata_next = {frames_reg, 13'h0, ovr_reg, pend_reg,
                                      (state_reg == ST_FRAME)};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
    // reading the word clears valid, a word landing the same cycle wins
    if (rd_data) begin
      word_next.valid = 1'b0;
      ovr_next = 1'b0;
    end
    if (done) begin
      // trailing bits after the converter has let go are dropped
      word_next.word = shift_in >> ctrl_reg.trim;
      word_next.valid = 1'b1;
      ovr_next = ovr_next || (word_reg.valid && !rd_data);
      frames_next = frames_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= '{trim: `SAR_TRIM_RST, wlf: `SAR_WLF_RST, en: `SAR_EN_RST};
      serial_clock_divider_reg <= `SAR_DIV_RST;
      intv_reg <= `SAR_INTV_RST;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      word_reg <= '0;
      ovr_reg <= 1'b0;
      frames_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      serial_clock_divider_reg <= serial_clock_divider_next;
      intv_reg <= intv_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      word_reg <= word_next;
      ovr_reg <= ovr_next;
      frames_reg <= frames_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign serial_clock = sclk_reg;
  assign transmit_frame_strobe_n = strobe_n_reg;
  assign sample_out = word_reg;

  // gap between frame starts, for checking only
  logic [31:0] gap_reg, gap_next, exp_gap;
  logic clean_reg, clean_next;

  always_comb begin
    gap_next = start ? 32'h0 : gap_reg + 32'h1;
    clean_next = wr_pend_reg ? 1'b0 : (start ? 1'b1 : clean_reg);
    exp_gap = 32'(intv_reg) * (32'(serial_clock_divider_reg) + 32'h1) * 32'h2;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 32'h0;
      clean_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      clean_reg <= clean_next;
    end
  end

  sequence s_leave_idle;
    state_reg == ST_IDLE ##1 state_reg == ST_SEEK_HI;
  endsequence

  sequence s_hi_lo_hi;
    state_reg == ST_SEEK_LO ##1 state_reg == ST_SEEK_HI2;
  endsequence

  a_idle_strobe_high: assert property (@(posedge mclk) disable iff (!rst_n)
    state_reg == ST_IDLE |-> strobe_n_reg)
    else $error("strobe low while idle");

  a_start_on_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(strobe_n_reg) |-> $rose(sclk_reg) && $past(state_reg) == ST_SEEK_HI2)
    else $error("frame did not start on a serial clock rise");

  a_seek_order: assert property (@(posedge mclk) disable iff (!rst_n)
    s_hi_lo_hi |-> !sclk_reg && $past(sclk_reg))
    else $error("seek passed low without high first");

  a_timer_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    s_leave_idle |-> $past(pend_reg))
    else $error("frame sought without timer expiry");

  a_word_bits: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(strobe_n_reg) && $past(ctrl_reg.en) |-> $past(bitcnt_reg) == $past(len) - 5'h1)
    else $error("frame ended at wrong bit count");

  a_equal_gap: assert property (@(posedge mclk) disable iff (!rst_n)
    start && clean_reg && !wr_pend_reg && intv_reg >= 16'(len) + `SAR_MIN_SLACK
      |-> gap_reg + 32'h1 == exp_gap)
    else $error("frame starts not equally spaced");

  a_capture_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    strobe_n_reg && !start |=> $stable(shift_reg))
    else $error("data captured outside a frame");

  a_trim_word: assert property (@(posedge mclk) disable iff (!rst_n)
    done |=> word_reg.valid && word_reg.word == ($past(shift_in) >> $past(ctrl_reg.trim)))
    else $error("stored word not the trimmed shift value");

  a_abort_release: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctrl_reg.en |=> strobe_n_reg && state_reg == ST_IDLE)
    else $error("strobe still low after disable");

endmodule

// file: test/sar_conv_model.sv
// behavioural serial converter facing the frame reader
`timescale 1ns/1ps
module sar_conv_model (
  input wire logic mclk,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] nbits,
  input wire logic [11:0] code,
  output logic dout
);
  logic [15:0] v;
  logic live;
  int k;
  initial begin
    dout = 1'b0;
    live = 1'b0;
    k = 0;
    v = 16'h0;
  end
  // sample taken and first leading zero shown at select fall
  always @(negedge cs_n) begin
    v = 16'({4'h0, code} << (12 - nbits));
    k = 0;
    live = 1'b1;
    dout = v[15];
  end
  always @(negedge sclk) begin
    if (live && !cs_n) begin
      k++;
      if (k >= nbits + 4) begin
        live = 1'b0;
      end else begin
        dout = v[15 - k];
      end
    end
  end
  always @(posedge cs_n) begin
    live = 1'b0;
  end
  // released line wanders every cycle
  always @(posedge mclk) begin
    #2;
    if (!live) begin
      dout = ~dout;
    end
  end
endmodule

// file: test/test_sar_reader.sv
// self-checking bench for the serial converter frame reader
`timescale 1ns/1ps
`include "sar_map.svh"
module test_sar_reader;
  import sar_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, serial_clock, strobe_n, sdo;
  logic [31:0] hrdata, rd;
  sar_word_t sample_out;
  logic [11:0] code = 12'h0;
  logic pst = 1'b1;
  logic psc = 1'b0;
  bit abort;
  int err_total = 0;
  int comparisons = 0;
  int seed = 32'h6C69;
  int nbi, len, trim, div, intv, cyc, last_fall, falls, pend, frames, expw;
  int exp_q[$];
  int nbt[5] = '{12, 10, 10, 8, 8};
  logic [3:0] wlt[5] = '{`SAR_WLF_16, `SAR_WLF_14, `SAR_WLF_16, `SAR_WLF_12, `SAR_WLF_16};
  int trt[5] = '{0, 0, 2, 0, 4};

  sar_reader DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_clock(serial_clock),
    .transmit_frame_strobe_n(strobe_n), .converter_serial_out(sdo), .sample_out(sample_out));
  sar_conv_model conv (.mclk(mclk), .cs_n(strobe_n), .sclk(serial_clock),
    .nbits(4'(nbi)), .code(code), .dout(sdo));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    cmp(hresp, 1'b0, "response");
  endtask

  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // frame watcher and reference word model
  always @(posedge mclk) begin
    cyc++;
    if (rst_n) begin
      if (!pst && psc && !serial_clock) falls++;
      if (pend > 0) begin
        pend--;
        if (pend == 0) begin
          cmp(32'(sample_out), {15'h0, 1'b1, 16'(expw)}, "sample word");
          frames++;
        end
      end
      if (pst && !strobe_n) begin
        cmp(serial_clock, 1'b1, "clock at frame start");
        if (last_fall > 0) cmp(cyc - last_fall, intv * 2 * (div + 1), "spacing");
        last_fall = cyc;
        falls = 0;
        exp_q.push_back(((int'(code) << (12 - nbi)) >> (16 - len)) >> trim);
      end
      if (!pst && strobe_n) begin
        if (!abort) cmp(falls, len, "frame length");
        expw = exp_q.pop_front();
        pend = abort ? 0 : 2;
        code <= 12'($random(seed)) & ((12'h1 << nbi) - 12'h1);
      end
    end
    pst = strobe_n;
    psc = serial_clock;
  end

  initial begin
    #1000000;
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge mclk);
    cmp({hrdata[30:0], serial_clock}, 32'h0, "outputs in reset");
    cmp({hrdata[31], hreadyout, hresp, sample_out}, 32'h0004_0000, "bus and word in reset");
    cmp(strobe_n, 1'b1, "strobe in reset");
    rst_n <= 1'b1;
    ahb(1'b0, `SAR_CTRL_OFS, 32'h0);
    cmp(rd, 32'h000000F0, "ctrl reset");
    ahb(1'b0, `SAR_DIV_OFS, 32'h0);
    cmp(rd, 32'h00000005, "div reset");
    ahb(1'b0, `SAR_INTV_OFS, 32'h0);
    cmp(rd, 32'h00000064, "interval reset");
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);
    cmp(rd, 32'h0, "unmapped");
    for (int i = 0; i < 6; i++) begin
      nbi = nbt[i % 5];
      len = wlt[i % 5] + 1;
      trim = trt[i % 5];
      div = 4 + ($random(seed) & 3);
      intv = len + 4;
      last_fall = 0;
      abort = (i == 5);
      code <= 12'($random(seed)) & ((12'h1 << nbi) - 12'h1);
      ahb(1'b1, `SAR_DIV_OFS, 32'(div));
      ahb(1'b1, `SAR_INTV_OFS, 32'(intv));
      ahb(1'b1, `SAR_CTRL_OFS, {21'h0, 3'(trim), wlt[i % 5], 4'h1});
      if (abort) begin
        while (strobe_n !== 1'b0) @(posedge mclk);
        repeat (30) @(posedge mclk);
      end else begin
        while (frames < 3 * (i + 1)) @(posedge mclk);
        ahb(1'b0, `SAR_STAT_OFS, 32'h0);
        cmp(32'({rd[31:16], rd[2:0]}), 32'({16'(frames), 3'b100}), "count and status");
        ahb(1'b0, `SAR_DATA_OFS, 32'h0);
        cmp(rd, {1'b1, 15'h0, 16'(expw)}, "data word");
      end
      ahb(1'b1, `SAR_CTRL_OFS, 32'h0);
      repeat (2) @(posedge mclk);
      cmp({serial_clock, strobe_n}, 2'b01, "stopped");
      ahb(1'b0, `SAR_DATA_OFS, 32'h0);
      cmp(rd[31], 1'b0, "valid cleared");
      ahb(1'b0, `SAR_STAT_OFS, 32'h0);
      cmp(rd[2:0], 3'h0, "status cleared");
    end
    end_of_test();
  end
endmodule
